// [scbc_core.sv]
// Stack frame handling, stack limit check, branch conditions and flags.
// Assumes decoder and datapath on pclk; the datapath supplies popped words.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Contract
// R1 - Allocate: push frame, frame=sp, sp+=literal
// R2 - Release: sp=frame, then pop frame pointer
// R3 - Limit register 16 bits, reset zero, bit0 zero
// R4 - Limit check enabled by word write, reset only
// R5 - Stack address above limit raises trap
// R6 - Stack address wrap past top raises trap
// R7 - Stack pointer resets 0x0800, below traps
// R8 - Compares update flags, store no result
// R9 - Branch taken only when condition true
// R10 - Single flag conditions test flags directly
// R11 - Signed conditions from negative, overflow, zero
// R12 - Unsigned conditions from carry and zero
// R13 - Accumulator overflow and saturation conditions
// R14 - Compare and skip leaves flags alone
// R15 - Carry input ops only clear zero
// R16 - Other ops set zero from result
// R17 - Stack pointer bit zero always clear
// R18 - Push post increments, pop pre decrements
// R19 - Frame pointer resets to zero
// R20 - Stack error is one cycle trap pulse
module scbc_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire scbc_pkg::scbc_sop_t stk_op,
    input wire logic [15:0] stk_lit,
    input wire logic [15:0] stk_wdata,
    input wire logic [15:0] stk_rdata,
    input wire logic [15:0] stk_ea,
    output logic [15:0] sp_q,
    output logic [15:0] fp_q,
    output logic mem_we_q,
    output logic [15:0] mem_addr_q,
    output logic [15:0] mem_wdata_q,
    output logic [15:0] pop_data_q,
    output logic stack_err_q,
    input wire scbc_pkg::scbc_aop_t alu_op,
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    input wire scbc_pkg::scbc_flags_t alu_flags,
    input wire logic alu_zero,
    output scbc_pkg::scbc_flags_t flags_q,
    input wire scbc_pkg::scbc_acc_t acc_flags,
    input wire logic br_valid,
    input wire scbc_pkg::scbc_cond_t br_cond,
    input wire logic [15:0] br_target,
    input wire logic [15:0] pc_seq,
    output logic [15:0] pc_q,
    output logic br_taken_q
);
    // ==========================================
    // Condition decode
    function automatic logic cond_eval(input scbc_pkg::scbc_cond_t cc,
                                       input scbc_pkg::scbc_flags_t f,
                                       input scbc_pkg::scbc_acc_t a);
        logic sge;
        sge = (f.n == f.signed_wrap_flag);
        unique case (cc)
            scbc_pkg::BC_C, scbc_pkg::BC_GEU: cond_eval = f.c; // see R10 see R12
            scbc_pkg::BC_NC, scbc_pkg::BC_LTU: cond_eval = !f.c; // see R10 see R12
            scbc_pkg::BC_GTU: cond_eval = f.c && !f.z; // see R12
            scbc_pkg::BC_LEU: cond_eval = !f.c || f.z; // see R12
            scbc_pkg::BC_GE: cond_eval = sge; // see R11
            scbc_pkg::BC_LT: cond_eval = !sge; // see R11
            scbc_pkg::BC_GT: cond_eval = !f.z && sge; // see R11
            scbc_pkg::BC_LE: cond_eval = f.z || !sge; // see R11
            scbc_pkg::BC_N: cond_eval = f.n; // see R10
            scbc_pkg::BC_NN: cond_eval = !f.n; // see R10
            scbc_pkg::BC_WRAP: cond_eval = f.signed_wrap_flag; // see R10
            scbc_pkg::BC_NOV: cond_eval = !f.signed_wrap_flag; // see R10
            scbc_pkg::BC_Z: cond_eval = f.z; // see R10
            scbc_pkg::BC_NZ: cond_eval = !f.z; // see R10
            scbc_pkg::BC_ACC_A_OVF: cond_eval = a.accum_a_overflow; // see R13
            scbc_pkg::BC_ACC_B_OVF: cond_eval = a.accum_b_overflow; // see R13
            scbc_pkg::BC_ACC_A_CLIP: cond_eval = a.accum_a_clipped; // see R13
            scbc_pkg::BC_ACC_B_CLIP: cond_eval = a.accum_b_clipped; // see R13
            default: cond_eval = 1'b0;
        endcase
    endfunction : cond_eval

    // ==========================================
    // APB slave
    logic [15:0] limit_q, limit_d;
    logic chk_q, chk_d;
    logic [31:0] prdata_d;
    logic wr_acc, rd_acc, mapped;

    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign mapped = (paddr == scbc_pkg::OFS_LIMIT) || (paddr == scbc_pkg::OFS_SP) ||
                    (paddr == scbc_pkg::OFS_FP) || (paddr == scbc_pkg::OFS_STAT);

    // Reads fetched in setup so access answers at once; writes land at the access edge
    always_comb begin
        limit_d = limit_q;
        chk_d = chk_q;
        prdata_d = prdata;
        if (wr_acc && paddr == scbc_pkg::OFS_LIMIT) begin
            if (pstrb[0]) begin
                limit_d[7:1] = pwdata[7:1];
            end
            if (pstrb[1]) begin
                limit_d[15:8] = pwdata[15:8];
            end
            limit_d[0] = 1'b0; // see R3
            // A partial write stores bytes but does not arm the check
            if (pstrb == scbc_pkg::STRB_ALL) begin
                chk_d = 1'b1; // see R4
            end
        end
        if (rd_acc) begin
            unique case (paddr)
                scbc_pkg::OFS_LIMIT: prdata_d = {16'h0000, limit_q};
                scbc_pkg::OFS_SP: prdata_d = {16'h0000, sp_q};
                scbc_pkg::OFS_FP: prdata_d = {16'h0000, fp_q};
                scbc_pkg::OFS_STAT: prdata_d = {27'h0, chk_q, flags_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_q <= scbc_pkg::LIMIT_RST; // see R3
            chk_q <= 1'b0; // see R4
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            limit_q <= limit_d;
            chk_q <= chk_d;
            prdata <= prdata_d;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // ==========================================
    // Stack pointer and frame pointer
    logic [15:0] sp_d, fp_d, ea, mem_addr_d, mem_wdata_d, pop_d;
    logic [16:0] sp_sum;
    logic ea_used, wrap, mem_we_d, err_d;

    always_comb begin
        sp_d = sp_q;
        fp_d = fp_q;
        ea = sp_q;
        ea_used = 1'b0;
        sp_sum = {1'b0, sp_q};
        mem_we_d = 1'b0;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        pop_d = pop_data_q;
        unique case (stk_op)
            scbc_pkg::SOP_PUSH: begin
                ea_used = 1'b1;
                mem_we_d = 1'b1;
                mem_addr_d = sp_q;
                mem_wdata_d = stk_wdata;
                sp_sum = {1'b0, sp_q} + {1'b0, scbc_pkg::WORD_STEP}; // see R18
            end
            scbc_pkg::SOP_POP: begin
                ea = sp_q - scbc_pkg::WORD_STEP; // see R18
                ea_used = 1'b1;
                mem_addr_d = ea;
                pop_d = stk_rdata;
                sp_sum = {1'b0, ea};
            end
            scbc_pkg::SOP_ALLOC: begin
                ea_used = 1'b1;
                mem_we_d = 1'b1;
                mem_addr_d = sp_q; // see R1
                mem_wdata_d = fp_q; // see R1
                fp_d = sp_q + scbc_pkg::WORD_STEP; // see R1
                sp_sum = {1'b0, sp_q} + {1'b0, scbc_pkg::WORD_STEP} + {1'b0, stk_lit};
            end
            scbc_pkg::SOP_RELEASE: begin
                ea = fp_q - scbc_pkg::WORD_STEP; // see R2
                ea_used = 1'b1;
                mem_addr_d = ea;
                fp_d = stk_rdata; // see R2
                sp_sum = {1'b0, ea};
            end
            scbc_pkg::SOP_EA: begin
                ea = stk_ea;
                ea_used = 1'b1;
            end
            default: begin
            end
        endcase
        if (stk_op != scbc_pkg::SOP_NONE && stk_op != scbc_pkg::SOP_EA) begin
            sp_d = {sp_sum[15:1], 1'b0}; // see R17
        end
        fp_d[0] = 1'b0;
        wrap = sp_sum[16];
        // Check covers the address used and the updated pointer
        err_d = ea_used && ((ea < scbc_pkg::SP_FLOOR) || (sp_d < scbc_pkg::SP_FLOOR) ||
                (chk_q && (ea > limit_q || sp_d > limit_q || wrap))); // see R5 see R6 see R7
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= scbc_pkg::SP_RST; // see R7
            fp_q <= scbc_pkg::FP_RST; // see R19
            mem_we_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_wdata_q <= 16'h0000;
            pop_data_q <= 16'h0000;
            stack_err_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            fp_q <= fp_d;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            pop_data_q <= pop_d;
            stack_err_q <= err_d; // see R20
        end
    end

    // ==========================================
    // Flags and compare
    scbc_pkg::scbc_flags_t flags_d;
    logic [16:0] diff;
    logic [15:0] sub_b;
    logic carry_kind;

    always_comb begin
        flags_d = flags_q;
        sub_b = (alu_op == scbc_pkg::AOP_CMP0) ? 16'h0000 : alu_b;
        // Borrow in is the complement of carry
        diff = {1'b0, alu_a} + {1'b0, ~sub_b} +
               ((alu_op == scbc_pkg::AOP_CMPB) ? {16'h0000, flags_q.c} : 17'h00001);
        carry_kind = (alu_op == scbc_pkg::AOP_CMPB) || (alu_op == scbc_pkg::AOP_LOADC);
        unique case (alu_op)
            scbc_pkg::AOP_CMP, scbc_pkg::AOP_CMP0, scbc_pkg::AOP_CMPB: begin
                flags_d.c = diff[16]; // see R8
                flags_d.n = diff[15];
                flags_d.signed_wrap_flag = (alu_a[15] != sub_b[15]) && (diff[15] != alu_a[15]);
                flags_d.z = (diff[15:0] == 16'h0000);
            end
            scbc_pkg::AOP_LOAD, scbc_pkg::AOP_LOADC: begin
                flags_d.c = alu_flags.c;
                flags_d.n = alu_flags.n;
                flags_d.signed_wrap_flag = alu_flags.signed_wrap_flag;
                flags_d.z = alu_zero; // see R16
            end
            default: begin
                flags_d = flags_q; // see R14
            end
        endcase
        if (carry_kind) begin
            flags_d.z = flags_q.z && flags_d.z; // see R15
        end
    end

    // ==========================================
    // Branch
    logic [15:0] pc_d;
    logic taken_d;

    always_comb begin
        taken_d = br_valid && cond_eval(br_cond, flags_q, acc_flags); // see R9
        pc_d = taken_d ? br_target : pc_seq; // see R9
        if (!br_valid) begin
            pc_d = pc_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
            pc_q <= 16'h0000;
            br_taken_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            pc_q <= pc_d;
            br_taken_q <= taken_d;
        end
    end

    // ==========================================
    // Assertions
    a_sp_aligned: assert property (@(posedge pclk) disable iff (!presetn)
        !sp_q[0]) else $error("stack pointer misaligned"); // see R17
    a_limit_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        !limit_q[0]) else $error("limit bit zero set"); // see R3
    a_chk_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        chk_q |=> chk_q) else $error("check disabled without reset"); // see R4
    a_chk_arm: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == scbc_pkg::OFS_LIMIT && pstrb == scbc_pkg::STRB_ALL) |=> chk_q)
        else $error("word write did not arm check"); // see R4
    a_floor_trap: assert property (@(posedge pclk) disable iff (!presetn)
        (stk_op == scbc_pkg::SOP_EA && stk_ea < scbc_pkg::SP_FLOOR) |=> stack_err_q)
        else $error("underflow not trapped"); // see R7
    a_limit_trap: assert property (@(posedge pclk) disable iff (!presetn)
        (chk_q && stk_op == scbc_pkg::SOP_EA && stk_ea > limit_q) |=> stack_err_q)
        else $error("overflow not trapped"); // see R5
    a_err_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (stk_op == scbc_pkg::SOP_NONE) |=> !stack_err_q)
        else $error("trap without address"); // see R20
    a_alloc_fp: assert property (@(posedge pclk) disable iff (!presetn)
        (stk_op == scbc_pkg::SOP_ALLOC) |=> (fp_q == $past(sp_q) + 16'h0002 && mem_we_q
        && mem_wdata_q == $past(fp_q))) else $error("allocate wrong"); // see R1
    a_push_step: assert property (@(posedge pclk) disable iff (!presetn)
        (stk_op == scbc_pkg::SOP_PUSH && sp_q < 16'hFFFE) |=> sp_q == $past(sp_q) + 16'h0002)
        else $error("push step wrong"); // see R18
    a_release_sp: assert property (@(posedge pclk) disable iff (!presetn)
        (stk_op == scbc_pkg::SOP_RELEASE) |=> sp_q == $past(fp_q) - 16'h0002)
        else $error("release sp wrong"); // see R2
    a_skip_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (alu_op == scbc_pkg::AOP_SKIP) |=> $stable(flags_q))
        else $error("skip changed flags"); // see R14
    a_zero_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (alu_op == scbc_pkg::AOP_LOADC && !flags_q.z) |=> !flags_q.z)
        else $error("zero set by carry op"); // see R15
    a_branch_pc: assert property (@(posedge pclk) disable iff (!presetn)
        (br_valid && !cond_eval(br_cond, flags_q, acc_flags)) |=> (pc_q == $past(pc_seq)
        && !br_taken_q)) else $error("untaken branch moved pc"); // see R9
    a_wrap_trap: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        (chk_q && stk_op == scbc_pkg::SOP_ALLOC &&
        ({1'b0, sp_q} + 17'h00002 + {1'b0, stk_lit}) > 17'h0FFFF) |=> stack_err_q)
        else $error("wrap not trapped");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    c_alloc_release: cover property (@(posedge pclk) disable iff (!presetn)
        stk_op == scbc_pkg::SOP_ALLOC ##[1:20] stk_op == scbc_pkg::SOP_RELEASE);
    c_trap: cover property (@(posedge pclk) disable iff (!presetn) chk_q && stack_err_q);
    c_taken: cover property (@(posedge pclk) disable iff (!presetn) br_taken_q);
    c_wrap: cover property (@(posedge pclk) disable iff (!presetn) chk_q && wrap);
endmodule : scbc_core

// [scbc_pkg.sv]
// Shared constants and types of the stack check and branch condition block.
// Assumes a 16-bit data space and a single core clock.
package scbc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] OFS_LIMIT = 8'h00;
    localparam logic [7:0] OFS_SP = 8'h04;
    localparam logic [7:0] OFS_FP = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    // ==========================================
    // Reset values and widths
    localparam int DW = 16;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0800;
    localparam logic [15:0] SP_FLOOR = 16'h0800;
    localparam logic [15:0] FP_RST = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [3:0] STRB_ALL = 4'hF;
    localparam int STAT_CHK = 4;
    // ==========================================
    // Types
    typedef struct packed {
        logic n;
        logic signed_wrap_flag;
        logic z;
        logic c;
    } scbc_flags_t;
    typedef struct packed {
        logic accum_a_overflow;
        logic accum_b_overflow;
        logic accum_a_clipped;
        logic accum_b_clipped;
    } scbc_acc_t;
    typedef enum logic [2:0] {
        SOP_NONE, SOP_PUSH, SOP_POP, SOP_ALLOC, SOP_RELEASE, SOP_EA
    } scbc_sop_t;
    typedef enum logic [2:0] {
        AOP_NONE, AOP_CMP, AOP_CMP0, AOP_CMPB, AOP_SKIP, AOP_LOAD, AOP_LOADC
    } scbc_aop_t;
    typedef enum logic [4:0] {
        BC_C, BC_GE, BC_GEU, BC_GT, BC_GTU, BC_LE, BC_LEU, BC_LT, BC_LTU,
        BC_N, BC_NC, BC_NN, BC_NOV, BC_NZ, BC_ACC_A_OVF, BC_ACC_B_OVF, BC_WRAP,
        BC_ACC_A_CLIP, BC_ACC_B_CLIP, BC_Z
    } scbc_cond_t;
endpackage : scbc_pkg

// [scbc_far_mem.sv]
// Far-side datapath model: a word memory filled by the block's write requests.
// Assumes registered pointers and a write pulse, both on pclk.
`timescale 1ns/10ps
module scbc_far_mem (
    input wire logic pclk,
    input wire scbc_pkg::scbc_sop_t stk_op,
    input wire logic [15:0] sp_q,
    input wire logic [15:0] fp_q,
    input wire logic mem_we_q,
    input wire logic [15:0] mem_addr_q,
    input wire logic [15:0] mem_wdata_q,
    output logic [15:0] stk_rdata
);
    // ==========================================
    // Storage
    logic [15:0] mem [0:32767];
    logic [15:0] rd_addr;
    // Unwritten words hold the inverse of their address, never a friendly zero
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = ~(16'(i) << 1);
        end
    end
    always @(posedge pclk) begin
        if (mem_we_q === 1'b1) begin
            mem[mem_addr_q[15:1]] <= mem_wdata_q;
        end
    end
    // Word below the pointer that the current op pops from
    assign rd_addr = (stk_op == scbc_pkg::SOP_POP) ? sp_q - 16'h0002 : fp_q - 16'h0002;
    assign stk_rdata = mem[rd_addr[15:1]];
endmodule : scbc_far_mem

// [test_stack_check_branch_cond.sv]
// Self-checking bench: APB limit register, stack ops, flags and branches.
// Assumes scbc_pkg and the far-side memory model are compiled first.
`timescale 1ns/10ps
module test_stack_check_branch_cond;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, er, mem_we_q, stack_err_q, br_valid = 1'b0, alu_zero = 1'b0;
    logic br_taken_q;
    logic [15:0] stk_lit = 16'h0, stk_wdata = 16'h0, stk_ea = 16'h0, stk_rdata;
    logic [15:0] alu_a = 16'h0, alu_b = 16'h0, br_target = 16'h0, pc_seq = 16'h0;
    logic [15:0] sp_q, fp_q, mem_addr_q, mem_wdata_q, pop_data_q, pc_q;
    scbc_pkg::scbc_sop_t stk_op = scbc_pkg::SOP_NONE;
    scbc_pkg::scbc_aop_t alu_op = scbc_pkg::AOP_NONE;
    scbc_pkg::scbc_flags_t alu_flags = 4'h0, flags_q;
    scbc_pkg::scbc_acc_t acc_flags = 4'h0;
    scbc_pkg::scbc_cond_t br_cond = scbc_pkg::BC_C;
    int fails = 0, checks_done = 0;
    always #50 pclk = ~pclk;
    // ==========================================
    // Design and far side
    scbc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stk_op(stk_op), .stk_lit(stk_lit),
        .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .stk_ea(stk_ea), .sp_q(sp_q),
        .fp_q(fp_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .pop_data_q(pop_data_q), .stack_err_q(stack_err_q), .alu_op(alu_op), .alu_a(alu_a),
        .alu_b(alu_b), .alu_flags(alu_flags), .alu_zero(alu_zero), .flags_q(flags_q),
        .acc_flags(acc_flags), .br_valid(br_valid), .br_cond(br_cond), .br_target(br_target),
        .pc_seq(pc_seq), .pc_q(pc_q), .br_taken_q(br_taken_q));
    scbc_far_mem far (.pclk(pclk), .stk_op(stk_op), .sp_q(sp_q), .fp_q(fp_q),
        .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .stk_rdata(stk_rdata));
    // ==========================================
    // Shared tasks
    task automatic conclude;
        $display("fails=%0d checks_done=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // Master holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            $display("MISMATCH %0t apb wait ran out", $time);
            conclude();
        end
    endtask : apb
    task automatic stk(input scbc_pkg::scbc_sop_t op, input logic [15:0] lit,
                       input logic [15:0] wd, input logic [15:0] ea);
        @(posedge pclk);
        stk_op <= op;
        stk_lit <= lit;
        stk_wdata <= wd;
        stk_ea <= ea;
        @(posedge pclk);
        stk_op <= scbc_pkg::SOP_NONE;
        #1;
    endtask : stk
    // Trap flag right after the op, then gone one cycle later
    task automatic trap(input scbc_pkg::scbc_sop_t op, input logic [15:0] lit,
                        input logic [15:0] ea, input logic exp);
        stk(op, lit, 16'h0, ea);
        chk(32'(stack_err_q), 32'(exp), "trap");
        @(posedge pclk);
        #1;
        chk(32'(stack_err_q), 32'h0, "trap width");
    endtask : trap
    task automatic alu(input scbc_pkg::scbc_aop_t op, input logic [15:0] a,
                       input logic [15:0] b, input logic [3:0] f, input logic z,
                       input logic [3:0] exp);
        @(posedge pclk);
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        alu_flags <= f;
        alu_zero <= z;
        @(posedge pclk);
        alu_op <= scbc_pkg::AOP_NONE;
        #1;
        chk(32'(flags_q), 32'(exp), "flags");
        chk(32'(mem_we_q), 32'h0, "no store");
    endtask : alu
    function automatic logic cond_ok(input scbc_pkg::scbc_cond_t k, input logic [3:0] f,
                                     input logic [3:0] a);
        logic n, v, z, c;
        {n, v, z, c} = f;
        case (k)
            scbc_pkg::BC_C: return c;
            scbc_pkg::BC_NC: return !c;
            scbc_pkg::BC_N: return n;
            scbc_pkg::BC_NN: return !n;
            scbc_pkg::BC_WRAP: return v;
            scbc_pkg::BC_NOV: return !v;
            scbc_pkg::BC_Z: return z;
            scbc_pkg::BC_NZ: return !z;
            scbc_pkg::BC_GE: return n == v;
            scbc_pkg::BC_LT: return n != v;
            scbc_pkg::BC_GT: return !z && n == v;
            scbc_pkg::BC_LE: return z || n != v;
            scbc_pkg::BC_GEU: return c;
            scbc_pkg::BC_LTU: return !c;
            scbc_pkg::BC_GTU: return c && !z;
            scbc_pkg::BC_LEU: return !c || z;
            scbc_pkg::BC_ACC_A_OVF: return a[3];
            scbc_pkg::BC_ACC_B_OVF: return a[2];
            scbc_pkg::BC_ACC_A_CLIP: return a[1];
            default: return a[0];
        endcase
    endfunction : cond_ok
    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk(32'(sp_q), 32'h0800, "sp reset");
        chk(32'(fp_q), 32'h0, "fp reset");
        apb(1'b0, scbc_pkg::OFS_LIMIT, 32'h0, 4'h0);
        chk(rd, 32'h0, "limit reset");
        apb(1'b0, 8'h10, 32'h0, 4'h0);
        chk(32'(er), 32'h1, "unmapped");
        apb(1'b1, scbc_pkg::OFS_SP, 32'h1234, 4'hF);
        chk(32'(sp_q), 32'h0800, "sp read only");
    endtask : t_reset
    task automatic t_stack;
        stk(scbc_pkg::SOP_PUSH, 16'h0, 16'h5A5A, 16'h0);
        chk(32'(mem_we_q), 32'h1, "push store");
        chk({mem_wdata_q, mem_addr_q}, {16'h5A5A, 16'h0800}, "push word");
        chk(32'(sp_q), 32'h0802, "push sp");
        stk(scbc_pkg::SOP_PUSH, 16'h0, 16'h3636, 16'h0);
        chk(32'(sp_q), 32'h0804, "push 2");
        stk(scbc_pkg::SOP_POP, 16'h0, 16'h0, 16'h0);
        chk({pop_data_q, sp_q}, {16'h3636, 16'h0802}, "pop");
        stk(scbc_pkg::SOP_ALLOC, 16'h0000, 16'h0, 16'h0);
        chk({fp_q, sp_q}, {16'h0804, 16'h0804}, "alloc");
        stk(scbc_pkg::SOP_ALLOC, 16'h0004, 16'h0, 16'h0);
        chk({mem_addr_q, mem_wdata_q}, {16'h0804, 16'h0804}, "alloc push");
        chk({fp_q, sp_q}, {16'h0806, 16'h080A}, "alloc ptrs");
        stk(scbc_pkg::SOP_RELEASE, 16'h0, 16'h0, 16'h0);
        chk({fp_q, sp_q}, {16'h0804, 16'h0804}, "release");
        stk(scbc_pkg::SOP_RELEASE, 16'h0, 16'h0, 16'h0);
        chk({fp_q, sp_q}, {16'h0000, 16'h0802}, "release 2");
        chk(32'(sp_q[0]), 32'h0, "sp aligned");
    endtask : t_stack
    task automatic t_limit;
        apb(1'b1, scbc_pkg::OFS_LIMIT, 32'h0811, 4'h3);
        trap(scbc_pkg::SOP_EA, 16'h0, 16'h0900, 1'b0);
        apb(1'b1, scbc_pkg::OFS_LIMIT, 32'h0811, 4'hF);
        apb(1'b0, scbc_pkg::OFS_LIMIT, 32'h0, 4'h0);
        chk(rd, 32'h0810, "limit bit0");
        apb(1'b0, scbc_pkg::OFS_STAT, 32'h0, 4'h0);
        chk(32'(rd[scbc_pkg::STAT_CHK]), 32'h1, "check on");
        trap(scbc_pkg::SOP_EA, 16'h0, 16'h0812, 1'b1);
        trap(scbc_pkg::SOP_EA, 16'h0, 16'h0810, 1'b0);
        trap(scbc_pkg::SOP_EA, 16'h0, 16'h07FE, 1'b1);
        trap(scbc_pkg::SOP_ALLOC, 16'hFFFC, 16'h0, 1'b1);
    endtask : t_limit
    task automatic t_flags;
        alu(scbc_pkg::AOP_CMP, 16'h0005, 16'h0005, 4'h0, 1'b0, 4'b0011);
        alu(scbc_pkg::AOP_CMP, 16'h0003, 16'h0005, 4'h0, 1'b0, 4'b1000);
        alu(scbc_pkg::AOP_CMP0, 16'h8000, 16'h0, 4'h0, 1'b0, 4'b1001);
        alu(scbc_pkg::AOP_CMPB, 16'h0005, 16'h0005, 4'h0, 1'b0, 4'b0001);
        alu(scbc_pkg::AOP_LOAD, 16'h0, 16'h0, 4'b0000, 1'b1, 4'b0010);
        alu(scbc_pkg::AOP_LOADC, 16'h0, 16'h0, 4'b0001, 1'b1, 4'b0011);
        alu(scbc_pkg::AOP_LOADC, 16'h0, 16'h0, 4'b0001, 1'b0, 4'b0001);
        alu(scbc_pkg::AOP_LOADC, 16'h0, 16'h0, 4'b0001, 1'b1, 4'b0001);
        alu(scbc_pkg::AOP_SKIP, 16'h0, 16'h0, 4'b1100, 1'b1, 4'b0001);
        alu(scbc_pkg::AOP_LOAD, 16'h0, 16'h0, 4'b1111, 1'b0, 4'b1101);
    endtask : t_flags
    // Every condition against every flag pattern, with the accumulator flags set to the same pattern
    task automatic t_branch;
        logic t;
        for (int f = 0; f < 16; f++) begin
            alu(scbc_pkg::AOP_LOAD, 16'h0, 16'h0, 4'(f), f[1], 4'(f));
            for (int k = 0; k < 20; k++) begin
                t = cond_ok(scbc_pkg::scbc_cond_t'(k), 4'(f), 4'(f));
                @(posedge pclk);
                br_valid <= 1'b1;
                br_cond <= scbc_pkg::scbc_cond_t'(k);
                acc_flags <= 4'(f);
                br_target <= 16'h1234;
                pc_seq <= 16'h0102;
                @(posedge pclk);
                br_valid <= 1'b0;
                #1;
                chk({pc_q, br_taken_q}, {t ? 16'h1234 : 16'h0102, t}, "branch");
            end
        end
    endtask : t_branch
    // Mid-run reset must clear the pointers and disarm the limit check
    task automatic t_rearm;
        stk(scbc_pkg::SOP_PUSH, 16'h0, 16'h1111, 16'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({fp_q, sp_q}, {16'h0000, 16'h0800}, "pointers after reset");
        apb(1'b0, scbc_pkg::OFS_STAT, 32'h0, 4'h0);
        chk(32'(rd[scbc_pkg::STAT_CHK]), 32'h0, "check off after reset");
        trap(scbc_pkg::SOP_EA, 16'h0, 16'h0900, 1'b0);
    endtask : t_rearm
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        t_stack();
        t_limit();
        t_flags();
        t_branch();
        t_rearm();
        conclude();
    end
endmodule : test_stack_check_branch_cond
